// ===== logic/cpu_ctl_cfg.svh
// Constants of the CPU control block: register offsets, reset values,
// fixed address map boundaries. Included by the design.
`ifndef CPU_CTL_CFG_SVH
`define CPU_CTL_CFG_SVH

// Register offsets on the AXI4-Lite slave
`define OFF_FLAGS       8'h00
`define OFF_PC          8'h04
`define OFF_STATUS      8'h08

// Reset values
`define FLAGS_RESET     8'h02
`define PC_RESET        16'h0000

// Flag word bit positions
`define BIT_IE          7
`define BIT_Z           6
`define BIT_BSH         5
`define BIT_AC          4
`define BIT_BSL         3
`define BIT_ZERO        2
`define BIT_ISP         1
`define BIT_CY          0

// Address map
`define VEC_LO          16'h0000
`define VEC_HI          16'h003f
`define TCALL_LO        16'h0040
`define TCALL_HI        16'h007f
`define FCALL_LO        16'h0800
`define FCALL_HI        16'h0fff
`define GREG_LO         16'hfee0
`define GREG_HI         16'hfeff
`define PERI_LO         16'hff00
`define RAM_TOP         16'hff00
`define NMI_INDEX       5'h01
`define IRQ_BASE_INDEX  5'h02

`endif

// ===== logic/cpu_ctl_pkg.sv
// Types shared by the CPU control block and its bench.
// Assumes cpu_ctl_cfg.svh for the numeric constants.
package cpu_ctl_pkg;

	typedef enum logic [2:0] {
		REG_VECTOR = 3'h0,
		REG_TCALL  = 3'h1,
		REG_FCALL  = 3'h2,
		REG_PROG   = 3'h3,
		REG_RAM    = 3'h4,
		REG_GREG   = 3'h5,
		REG_PERI   = 3'h6,
		REG_NONE   = 3'h7
	} region_t;

	typedef enum logic [2:0] {
		ST_VEC_REQ = 3'h0,
		ST_VEC_LO  = 3'h1,
		ST_VEC_HI  = 3'h2,
		ST_RUN     = 3'h3,
		ST_PUSH_F  = 3'h4,
		ST_PUSH_H  = 3'h5,
		ST_PUSH_L  = 3'h6
	} state_t;

	// Events from the instruction sequencer, same clock
	typedef struct packed {
		logic        boundary;
		logic        advance;
		logic [2:0]  length;
		logic        branch;
		logic [15:0] target;
		logic        unmask_all;
		logic        mask_all;
		logic        bank_choose;
		logic [1:0]  bank;
		logic        push_flags;
		logic        pop_flags;
		logic [7:0]  pop_data;
		logic        alu_valid;
		logic [7:0]  alu_a;
		logic [7:0]  alu_b;
		logic        alu_sub;
		logic [7:0]  alu_result;
		logic        alu_carry;
	} core_ctl_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
	} mem_req_t;

	typedef struct packed {
		logic        busy;
		logic        accept;
		logic [4:0]  accept_index;
		logic [1:0]  bank;
	} core_stat_t;

endpackage : cpu_ctl_pkg

// ===== logic/cpu_ctl_regs.sv
// CPU control state: program counter, flag word, interrupt acceptance,
// vector loading and the fixed 64K address decode, with an AXI4-Lite slave.
// Assumes a sequencer on i_clk and a byte memory answering with rvalid.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_ctl_cfg.svh"

module cpu_ctl_regs #(
	parameter int PROG_BYTES = 24576,
	parameter int RAM_BYTES  = 512,
	parameter int N_IRQ      = 9
) (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	// AXI4-Lite slave
	input  wire logic                   i_awvalid,
	output logic                        o_awready,
	input  wire logic [7:0]             i_awaddr,
	input  wire logic                   i_wvalid,
	output logic                        o_wready,
	input  wire logic [31:0]            i_wdata,
	input  wire logic [3:0]             i_wstrb,
	output logic                        o_bvalid,
	input  wire logic                   i_bready,
	output logic [1:0]                  o_bresp,
	input  wire logic                   i_arvalid,
	output logic                        o_arready,
	input  wire logic [7:0]             i_araddr,
	output logic                        o_rvalid,
	input  wire logic                   i_rready,
	output logic [31:0]                 o_rdata,
	output logic [1:0]                  o_rresp,
	// Sequencer side
	input  wire cpu_ctl_pkg::core_ctl_t i_ctl,
	input  wire logic [15:0]            i_sp,
	input  wire logic [15:0]            i_data_addr,
	output cpu_ctl_pkg::core_stat_t     o_stat,
	output logic [15:0]                 o_pc,
	output logic [7:0]                  o_flags,
	output cpu_ctl_pkg::region_t        o_fetch_region,
	output cpu_ctl_pkg::region_t        o_data_region,
	// Interrupt requests
	input  wire logic                   i_nmi,
	input  wire logic [N_IRQ-1:0]       i_irq,
	input  wire logic [N_IRQ-1:0]       i_irq_mask,
	input  wire logic [N_IRQ-1:0]       i_irq_low_prio,
	// Byte memory port
	output cpu_ctl_pkg::mem_req_t       o_mem,
	input  wire logic [7:0]             i_mem_rdata,
	input  wire logic                   i_mem_rvalid
);

	// Sizes the map cannot hold are refused at elaboration; index 31 is the
	// last vector slot, so at most 30 maskable sources fit
	if (!(PROG_BYTES == 8192 || PROG_BYTES == 16384 || PROG_BYTES == 24576))
	begin : bad_prog_size
		$error("PROG_BYTES not supported");
	end
	if (!(RAM_BYTES == 256 || RAM_BYTES == 384 || RAM_BYTES == 512))
	begin : bad_ram_size
		$error("RAM_BYTES not supported");
	end
	if (N_IRQ < 1 || N_IRQ > 30)
	begin : bad_irq_count
		$error("N_IRQ out of range");
	end

	// Program end and RAM floor follow the variant sizes
	localparam logic [15:0] PROG_END = 16'(PROG_BYTES);
	localparam logic [15:0] RAM_LO   = 16'(`RAM_TOP - RAM_BYTES);

	// Fixed map decode, shared by fetch and data paths
	function automatic cpu_ctl_pkg::region_t decode(input logic [15:0] a);
		cpu_ctl_pkg::region_t r;
		r = cpu_ctl_pkg::REG_NONE;
		if (a >= `PERI_LO)
			r = cpu_ctl_pkg::REG_PERI;
		else if (a >= `GREG_LO)
			r = cpu_ctl_pkg::REG_GREG;
		else if (a >= RAM_LO)
			r = cpu_ctl_pkg::REG_RAM;
		else if (a <= `VEC_HI)
			r = cpu_ctl_pkg::REG_VECTOR;
		else if (a <= `TCALL_HI)
			r = cpu_ctl_pkg::REG_TCALL;
		else if (a >= `FCALL_LO && a <= `FCALL_HI)
			r = cpu_ctl_pkg::REG_FCALL;
		else if (a < PROG_END)
			r = cpu_ctl_pkg::REG_PROG;
		return r;
	endfunction : decode

	// Carry out of bit 3 on add, borrow into bit 3 on subtract
	function automatic logic half_carry(input logic [7:0] a, input logic [7:0] b,
		input logic sub);
		logic [4:0] s;
		s = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]}) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
		return s[4];
	endfunction : half_carry

	// Sequencer state, stacked flags and held write halves
	cpu_ctl_pkg::state_t state;
	cpu_ctl_pkg::state_t next_state;
	logic [7:0]  saved_flags;
	logic [7:0]  vec_lo;
	logic [4:0]  src_index;
	logic        aw_got;
	logic        w_got;
	logic [7:0]  waddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;

	// Interrupt eligibility and lowest-index pick
	wire logic             ie  = o_flags[`BIT_IE];
	wire logic             inservice_priority_flag = o_flags[`BIT_ISP];
	wire logic [N_IRQ-1:0] eligible = i_irq & ~i_irq_mask & (~i_irq_low_prio | {N_IRQ{inservice_priority_flag}})
		& {N_IRQ{ie}};
	logic [4:0] pick;
	always_comb
	begin
		pick = 5'h00;
		for (int k = N_IRQ - 1; k >= 0; k--)
			if (eligible[k])
				pick = 5'(k) + `IRQ_BASE_INDEX;
	end
	// Entry waits for a boundary outside a push so stack writes never interleave
	wire logic in_run  = (state == cpu_ctl_pkg::ST_RUN);
	wire logic take    = in_run && i_ctl.boundary && !i_ctl.push_flags
		&& (i_nmi || eligible != '0);
	wire logic [4:0] take_index = i_nmi ? `NMI_INDEX : pick;
	wire logic [15:0] vec_addr = {10'h000, src_index, 1'b0};

	// AXI write channel handshakes; both halves in either order
	wire logic aw_fire  = i_awvalid && o_awready;
	wire logic w_fire   = i_wvalid && o_wready;
	wire logic [7:0]  aw_a = aw_fire ? i_awaddr : waddr;
	wire logic [31:0] w_d  = w_fire ? i_wdata : wdata;
	wire logic [3:0]  w_s  = w_fire ? i_wstrb : wstrb;
	wire logic do_write = (aw_got || aw_fire) && (w_got || w_fire) && !o_bvalid;
	wire logic wr_flags = do_write && aw_a == `OFF_FLAGS && w_s[0];
	wire logic wr_pc    = do_write && aw_a == `OFF_PC;
	wire logic wr_ok    = aw_a == `OFF_FLAGS || aw_a == `OFF_PC || aw_a == `OFF_STATUS;
	wire logic next_aw_got = (aw_got || aw_fire) && !do_write;
	wire logic next_w_got  = (w_got || w_fire) && !do_write;
	wire logic next_bvalid = do_write || (o_bvalid && !i_bready);

	// AXI read channel
	wire logic ar_fire = i_arvalid && o_arready;
	wire logic next_rvalid = ar_fire || (o_rvalid && !i_rready);
	wire logic rd_ok = i_araddr == `OFF_FLAGS || i_araddr == `OFF_PC
		|| i_araddr == `OFF_STATUS;
	wire logic [31:0] rd_val =
		(i_araddr == `OFF_FLAGS)  ? {24'h000000, o_flags} :
		(i_araddr == `OFF_PC)     ? {16'h0000, o_pc} :
		(i_araddr == `OFF_STATUS) ? {24'h000000, o_stat.busy, state, src_index[3:0]} :
		32'h00000000;

	// Flag word next value; accept clears IE after all other sources
	logic [7:0] next_flags;
	always_comb
	begin
		next_flags = o_flags;
		if (in_run && i_ctl.alu_valid)
		begin
			next_flags[`BIT_Z]  = (i_ctl.alu_result == 8'h00);
			next_flags[`BIT_AC] = half_carry(i_ctl.alu_a, i_ctl.alu_b, i_ctl.alu_sub);
			next_flags[`BIT_CY] = i_ctl.alu_carry;
		end
		if (in_run && i_ctl.bank_choose)
			{next_flags[`BIT_BSH], next_flags[`BIT_BSL]} = i_ctl.bank;
		if (in_run && i_ctl.pop_flags)
			next_flags = i_ctl.pop_data;
		if (in_run && i_ctl.unmask_all)
			next_flags[`BIT_IE] = 1'b1;
		if (in_run && i_ctl.mask_all)
			next_flags[`BIT_IE] = 1'b0;
		if (wr_flags)
			next_flags = w_d[7:0];
		if (take)
			next_flags[`BIT_IE] = 1'b0;
		next_flags[`BIT_ZERO] = 1'b0;
	end

	// Program counter next value
	logic [15:0] next_pc;
	always_comb
	begin
		next_pc = o_pc;
		if (in_run && i_ctl.branch)
			next_pc = i_ctl.target;
		else if (in_run && i_ctl.advance)
			next_pc = o_pc + {13'h0000, i_ctl.length};
		if (wr_pc && in_run)
		begin
			if (w_s[0])
				next_pc[7:0] = w_d[7:0];
			if (w_s[1])
				next_pc[15:8] = w_d[15:8];
		end
		if (state == cpu_ctl_pkg::ST_VEC_HI && i_mem_rvalid)
			next_pc = {i_mem_rdata, vec_lo};
	end

	// Sequencer: vector fetch and interrupt stacking
	cpu_ctl_pkg::mem_req_t next_mem;
	always_comb
	begin
		next_state = state;
		next_mem   = '0;
		case (state)
			cpu_ctl_pkg::ST_VEC_REQ:
			begin
				next_mem.rd   = 1'b1;
				next_mem.addr = vec_addr;
				next_state    = cpu_ctl_pkg::ST_VEC_LO;
			end
			cpu_ctl_pkg::ST_VEC_LO:
				if (i_mem_rvalid)
				begin
					next_mem.rd   = 1'b1;
					next_mem.addr = vec_addr | 16'h0001;
					next_state    = cpu_ctl_pkg::ST_VEC_HI;
				end
			cpu_ctl_pkg::ST_VEC_HI:
				if (i_mem_rvalid)
					next_state = cpu_ctl_pkg::ST_RUN;
			cpu_ctl_pkg::ST_RUN:
				if (take)
					next_state = cpu_ctl_pkg::ST_PUSH_F;
				else if (i_ctl.push_flags)
				begin
					next_mem.wr    = 1'b1;
					next_mem.addr  = i_sp - 16'h0001;
					next_mem.wdata = o_flags;
				end
			cpu_ctl_pkg::ST_PUSH_F:
			begin
				next_mem.wr    = 1'b1;
				next_mem.addr  = i_sp - 16'h0001;
				next_mem.wdata = saved_flags;
				next_state     = cpu_ctl_pkg::ST_PUSH_H;
			end
			cpu_ctl_pkg::ST_PUSH_H:
			begin
				next_mem.wr    = 1'b1;
				next_mem.addr  = i_sp - 16'h0002;
				next_mem.wdata = o_pc[15:8];
				next_state     = cpu_ctl_pkg::ST_PUSH_L;
			end
			cpu_ctl_pkg::ST_PUSH_L:
			begin
				next_mem.wr    = 1'b1;
				next_mem.addr  = i_sp - 16'h0003;
				next_mem.wdata = o_pc[7:0];
				next_state     = cpu_ctl_pkg::ST_VEC_REQ;
			end
			default:
				next_state = cpu_ctl_pkg::ST_VEC_REQ;
		endcase
	end

	// Control state and core-facing outputs
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			state          <= cpu_ctl_pkg::ST_VEC_REQ;
			o_flags        <= `FLAGS_RESET;
			o_pc           <= `PC_RESET;
			saved_flags    <= `FLAGS_RESET;
			src_index      <= 5'h00;
			vec_lo         <= 8'h00;
			o_mem          <= '0;
			o_stat         <= '0;
			o_fetch_region <= cpu_ctl_pkg::REG_VECTOR;
			o_data_region  <= cpu_ctl_pkg::REG_VECTOR;
		end
		else
		begin
			state          <= next_state;
			o_flags        <= next_flags;
			o_pc           <= next_pc;
			o_mem          <= next_mem;
			o_fetch_region <= decode(next_pc);
			o_data_region  <= decode(i_data_addr);
			if (take)
			begin
				saved_flags <= o_flags;                    // Value before IE clears
				src_index   <= take_index;
			end
			if (state == cpu_ctl_pkg::ST_VEC_LO && i_mem_rvalid)
				vec_lo <= i_mem_rdata;
			o_stat.busy         <= next_state != cpu_ctl_pkg::ST_RUN;
			o_stat.accept       <= take;
			o_stat.accept_index <= take ? take_index : o_stat.accept_index;
			o_stat.bank         <= {next_flags[`BIT_BSH], next_flags[`BIT_BSL]};
		end
	end

	// AXI4-Lite slave registers; unmapped offsets answer SLVERR
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			aw_got    <= 1'b0;
			w_got     <= 1'b0;
			waddr     <= 8'h00;
			wdata     <= 32'h00000000;
			wstrb     <= 4'h0;
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= 2'h0;
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h00000000;
			o_rresp   <= 2'h0;
		end
		else
		begin
			aw_got    <= next_aw_got;
			w_got     <= next_w_got;
			waddr     <= aw_a;
			wdata     <= w_d;
			wstrb     <= w_s;
			o_awready <= !next_aw_got && !next_bvalid;
			o_wready  <= !next_w_got && !next_bvalid;
			o_bvalid  <= next_bvalid;
			// Response codes change only when a transfer is taken
			if (do_write)
				o_bresp <= wr_ok ? 2'h0 : 2'h2;
			o_arready <= !next_rvalid;
			o_rvalid  <= next_rvalid;
			if (ar_fire)
			begin
				o_rdata <= rd_val;
				o_rresp <= rd_ok ? 2'h0 : 2'h2;
			end
		end
	end

endmodule : cpu_ctl_regs

`default_nettype wire

// ===== tb/cpu_ctl_regs_checker.sv
// Assertions on flag word, program counter and interrupt entry.
// Assumes it is bound into every cpu_ctl_regs instance.
`timescale 1ns/1ps
`default_nettype none
module cpu_ctl_regs_checker (
	// Clock, reset and inputs
	input wire logic                    i_clk,
	input wire logic                    i_rst_n,
	input wire logic                    i_wvalid,
	input wire logic                    i_nmi,
	input wire cpu_ctl_pkg::core_ctl_t  i_ctl,
	// Outputs watched
	input wire cpu_ctl_pkg::core_stat_t o_stat,
	input wire logic [15:0]             o_pc,
	input wire logic [7:0]              o_flags,
	input wire cpu_ctl_pkg::mem_req_t   o_mem
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// Core events count only when idle, so no register write or entry races them
	wire quiet = !o_stat.busy && !i_wvalid && !i_ctl.boundary;

	// Three back-to-back stack writes of interrupt entry
	sequence stack_three;
		o_mem.wr ##1 o_mem.wr ##1 o_mem.wr;
	endsequence

	flags_reset_a: assert property (disable iff (1'b0) !i_rst_n |=> o_flags == 8'h02)
		else $error("flag word not 02 after reset");
	vector_fetch_a: assert property ($rose(i_rst_n) |=> o_mem.rd && o_mem.addr == 16'h0000)
		else $error("no vector read at 0000 after reset");
	bit_two_a: assert property (o_flags[2] == 1'b0)
		else $error("flag bit 2 not zero");
	bank_bits_a: assert property (o_stat.bank == {o_flags[5], o_flags[3]})
		else $error("bank select does not match flag bits");
	mask_clears_a: assert property (quiet && i_ctl.mask_all |=> !o_flags[7])
		else $error("mask-all left enable set");
	unmask_sets_a: assert property (quiet && i_ctl.unmask_all && !i_ctl.mask_all |=> o_flags[7])
		else $error("unmask-all left enable clear");
	pc_advance_a: assert property (quiet && i_ctl.advance && !i_ctl.branch
		|=> o_pc == $past(o_pc) + 16'($past(i_ctl.length)))
		else $error("pc did not advance by length");
	pc_branch_a: assert property (quiet && i_ctl.branch |=> o_pc == $past(i_ctl.target))
		else $error("pc did not load branch target");
	ie_refuse_a: assert property (!o_stat.busy && i_ctl.boundary && !o_flags[7] && !i_nmi
		&& !i_wvalid |=> !o_stat.accept)
		else $error("interrupt taken with enable clear");
	accept_ie_a: assert property (o_stat.accept |-> !o_flags[7] && o_stat.busy)
		else $error("enable not cleared on acceptance");
	entry_stack_a: assert property (o_stat.accept |=> stack_three)
		else $error("entry did not stack three bytes");
endmodule : cpu_ctl_regs_checker

bind cpu_ctl_regs cpu_ctl_regs_checker cpu_ctl_regs_checker_i (.i_clk, .i_rst_n, .i_wvalid,
	.i_nmi, .i_ctl, .o_stat, .o_pc, .o_flags, .o_mem);
`default_nettype wire

// ===== tb/cpu_ctl_regs_memory_map_test.sv
// Bench for cpu_ctl_regs: register access, core events, decode, interrupt entry.
// Assumes default parameters and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module cpu_ctl_regs_memory_map_test;
	logic                    i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic                    i_nmi, i_mem_rvalid, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [7:0]              i_awaddr, i_araddr, i_mem_rdata, o_flags, mem [0:255];
	logic [31:0]             i_wdata, o_rdata;
	logic [3:0]              i_wstrb;
	logic [1:0]              o_bresp, o_rresp;
	logic [15:0]             i_sp, i_data_addr, o_pc;
	logic [8:0]              i_irq, i_irq_mask, i_irq_low_prio;
	logic [4:0]              acc_idx;
	logic [23:0]             wlog [$];
	cpu_ctl_pkg::core_ctl_t  i_ctl;
	cpu_ctl_pkg::core_stat_t o_stat;
	cpu_ctl_pkg::region_t    o_fetch_region, o_data_region;
	cpu_ctl_pkg::mem_req_t   o_mem;
	int                      failures, tests_run, acc_cnt, abase, wbase;
	// Region code above address
	logic [18:0]             ftab [4] = '{{cpu_ctl_pkg::REG_VECTOR, 16'h0010},
		{cpu_ctl_pkg::REG_TCALL, 16'h0040}, {cpu_ctl_pkg::REG_FCALL, 16'h0fff},
		{cpu_ctl_pkg::REG_PROG, 16'h5fff}};
	logic [18:0]             dtab [8] = '{{cpu_ctl_pkg::REG_PERI, 16'hff00},
		{cpu_ctl_pkg::REG_PERI, 16'hffff}, {cpu_ctl_pkg::REG_GREG, 16'hfeff},
		{cpu_ctl_pkg::REG_GREG, 16'hfee0}, {cpu_ctl_pkg::REG_RAM, 16'hfedf},
		{cpu_ctl_pkg::REG_RAM, 16'hfd00}, {cpu_ctl_pkg::REG_NONE, 16'hfcff},
		{cpu_ctl_pkg::REG_TCALL, 16'h0040}};

	cpu_ctl_regs cpu_ctl_regs_i (.i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
		.o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
		.i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_ctl, .i_sp, .i_data_addr,
		.o_stat, .o_pc, .o_flags, .o_fetch_region, .o_data_region, .i_nmi, .i_irq,
		.i_irq_mask, .i_irq_low_prio, .o_mem, .i_mem_rdata, .i_mem_rvalid);

	// 25 MHz clock
	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// Byte memory answering one cycle after each read; logs writes and entries
	always @(posedge i_clk)
	begin
		i_mem_rvalid <= o_mem.rd;
		i_mem_rdata  <= mem[o_mem.addr[7:0]];
		if (o_mem.wr === 1'b1)
			wlog.push_back({o_mem.addr, o_mem.wdata});
		if (o_stat.accept === 1'b1)
		begin
			acc_cnt <= acc_cnt + 1;
			acc_idx <= o_stat.accept_index;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop;
		$display("tests_run %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	// A used-up wait bound counts as a mismatch and ends the run
	task automatic guard(input int n);
		if (n >= 200)
		begin
			failures++;
			report_and_stop();
		end
	endtask : guard

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int   n;
		logic done;
		done = 1'b0;
		@(posedge i_clk);
		i_awvalid <= 1'b1;
		i_awaddr  <= a;
		i_wvalid  <= 1'b1;
		i_wdata   <= d;
		i_bready  <= 1'b1;
		for (n = 0; n < 200 && !done; n++)
		begin
			@(posedge i_clk);
			if (i_awvalid && o_awready)
				i_awvalid <= 1'b0;
			if (i_wvalid && o_wready)
				i_wvalid <= 1'b0;
			done = (o_bvalid === 1'b1);
		end
		r = o_bresp;
		i_bready <= 1'b0;
		guard(n);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int   n;
		logic done;
		done = 1'b0;
		@(posedge i_clk);
		i_arvalid <= 1'b1;
		i_araddr  <= a;
		i_rready  <= 1'b1;
		for (n = 0; n < 200 && !done; n++)
		begin
			@(posedge i_clk);
			if (i_arvalid && o_arready)
				i_arvalid <= 1'b0;
			done = (o_rvalid === 1'b1);
		end
		d = o_rdata;
		r = o_rresp;
		i_rready <= 1'b0;
		guard(n);
	endtask : axi_rd

	// One cycle of core events, outputs settled on return
	task automatic core_evt(input cpu_ctl_pkg::core_ctl_t c);
		@(posedge i_clk);
		i_ctl <= c;
		@(posedge i_clk);
		i_ctl <= '0;
		#1;
	endtask : core_evt

	task automatic wait_idle;
		int n;
		for (n = 0; n < 200 && o_stat.busy !== 1'b0; n++)
			@(posedge i_clk);
		guard(n);
		#1;
	endtask : wait_idle

	// Sets flags, mask and priority of source 0, offers one boundary
	task automatic irq_try(input logic [7:0] f, input logic m, lp, input int n);
		logic [1:0]             r;
		cpu_ctl_pkg::core_ctl_t c;
		c = '0;
		c.boundary = 1'b1;
		axi_wr(8'h00, {24'h0, f}, r);
		i_irq_mask     <= {8'hff, m};
		i_irq_low_prio <= {8'h00, lp};
		wbase = wlog.size();
		abase = acc_cnt;
		core_evt(c);
		repeat (3) @(posedge i_clk);
		wait_idle();
		check("accepts", acc_cnt - abase, n);
	endtask : irq_try

	// Main sequence
	initial
	begin
		cpu_ctl_pkg::core_ctl_t c;
		logic [31:0]            d;
		logic [1:0]             r;
		{i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_nmi} = '0;
		{i_awaddr, i_araddr, i_wdata, i_data_addr, i_irq, i_irq_low_prio} = '0;
		i_ctl = '0;
		i_wstrb = 4'hf;
		i_irq_mask = '1;
		i_sp = 16'hfe80;
		for (int k = 0; k < 256; k++)
			mem[k] = 8'(k) + 8'h11;
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		wait_idle();
		check("reset flags", o_flags, 8'h02);
		axi_rd(8'h04, d, r);
		check("reset pc", d, {16'h0, mem[1], mem[0]});
		check("pc rresp", r, 2'h0);
		axi_wr(8'h0c, 32'h0, r);
		check("unmapped bresp", r, 2'h2);
		axi_wr(8'h00, 32'hff, r);
		axi_rd(8'h00, d, r);
		check("flags ff", d, 32'hfb);
		c = '0;
		c.bank_choose = 1'b1;
		c.bank = 2'h2;
		core_evt(c);
		check("bank", {o_stat.bank, o_flags[5], o_flags[3]}, 4'ha);
		// Half carry out of bit 3, then a zero difference
		c = '0;
		c.alu_valid = 1'b1;
		c.alu_a = 8'h0f;
		c.alu_b = 8'h01;
		c.alu_result = 8'h10;
		core_evt(c);
		check("add flags", {o_flags[6], o_flags[4], o_flags[0]}, 3'b010);
		c.alu_a = 8'h10;
		c.alu_b = 8'h10;
		c.alu_sub = 1'b1;
		c.alu_result = 8'h00;
		core_evt(c);
		check("sub flags", {o_flags[6], o_flags[4], o_flags[0]}, 3'b100);
		c = '0;
		c.mask_all = 1'b1;
		core_evt(c);
		check("mask all", o_flags[7], 1'b0);
		c = '0;
		c.unmask_all = 1'b1;
		core_evt(c);
		check("unmask all", o_flags[7], 1'b1);
		// PC write lands in run; a flag write without lane 0 is dropped
		axi_wr(8'h04, 32'h0000abcd, r);
		check("pc write", {r, o_pc}, {2'h0, 16'habcd});
		i_wstrb <= 4'he;
		axi_wr(8'h00, 32'h00000000, r);
		i_wstrb <= 4'hf;
		check("flags strobe", {r, o_flags}, {2'h0, 8'he2});
		foreach (ftab[k])
		begin
			c = '0;
			c.branch = 1'b1;
			c.target = ftab[k][15:0];
			core_evt(c);
			check("branch pc", o_pc, ftab[k][15:0]);
			check("fetch region", o_fetch_region, ftab[k][18:16]);
		end
		c = '0;
		c.advance = 1'b1;
		c.length = 3'h3;
		core_evt(c);
		check("advance", {o_fetch_region, o_pc}, {cpu_ctl_pkg::REG_NONE, 16'h6002});
		foreach (dtab[k])
		begin
			@(posedge i_clk);
			i_data_addr <= dtab[k][15:0];
			repeat (2) @(posedge i_clk);
			#1;
			check("data region", o_data_region, dtab[k][18:16]);
		end
		// Push and pop of the flag word
		axi_wr(8'h00, 32'h4a, r);
		wbase = wlog.size();
		c = '0;
		c.push_flags = 1'b1;
		core_evt(c);
		repeat (2) @(posedge i_clk);
		check("push", wlog[wbase], 24'hfe7f4a);
		c = '0;
		c.pop_flags = 1'b1;
		c.pop_data = 8'h35;
		core_evt(c);
		check("pop", o_flags, 8'h31);
		// Maskable gating, then entry of source 0
		i_irq <= 9'h001;
		irq_try(8'h00, 1'b0, 1'b0, 0);
		irq_try(8'h80, 1'b0, 1'b1, 0);
		irq_try(8'h82, 1'b1, 1'b1, 0);
		irq_try(8'h82, 1'b0, 1'b1, 1);
		check("entry stack flags", wlog[wbase], 24'hfe7f82);
		check("entry stack pc high", wlog[wbase + 1], 24'hfe7e60);
		check("entry stack pc low", wlog[wbase + 2], 24'hfe7d02);
		check("entry pc", {acc_idx, o_pc, o_flags}, {5'h02, mem[5], mem[4], 8'h02});
		i_irq <= 9'h000;
		i_nmi <= 1'b1;
		irq_try(8'h00, 1'b1, 1'b0, 1);
		i_nmi <= 1'b0;
		check("nmi entry", {acc_idx, o_pc}, {5'h01, mem[3], mem[2]});
		// Status shows run state and the last source; unmapped reads answer an error
		axi_rd(8'h08, d, r);
		check("status", d, 32'h00000031);
		check("status rresp", r, 2'h0);
		axi_rd(8'h0c, d, r);
		check("unmapped rdata", d, 32'h00000000);
		check("unmapped rresp", r, 2'h2);
		report_and_stop();
	end
endmodule : cpu_ctl_regs_memory_map_test
`default_nettype wire
